// ==== rtl/bxc_exchanger.sv ====
// Purpose: 12-bit narrow port to two 12-bit wide banks, both directions.
// Assumes: Pin inputs are synchronous to pclk; *_ext_drive tells whether
//          the far party drives the pin this cycle.
// Notes:   APB window exposes a keeper control and read-only state.
//
// Register access over APB and the register addresses were left to the implementer.
`include "bxc_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module bxc_exchanger (
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Control pins
    input  wire logic              bank_one_capture_enable_n,
    input  wire logic              bank_two_capture_enable_n,
    input  wire logic              bank_one_latch_open_n,
    input  wire logic              bank_two_latch_open_n,
    input  wire logic              bank_select,
    input  wire logic              narrow_drive_enable_n,
    input  wire logic              wide_drive_enable_n,
    // Narrow port
    input  wire bxc_pkg::bxc_word_t narrow_in,
    input  wire logic              narrow_ext_drive,
    output bxc_pkg::bxc_word_t     narrow_out,
    output logic                   narrow_oe,
    // Wide bank one
    input  wire bxc_pkg::bxc_word_t wide_bank_one_in,
    input  wire logic              wide_bank_one_ext_drive,
    output bxc_pkg::bxc_word_t     wide_bank_one_out,
    output logic                   wide_bank_one_oe,
    // Wide bank two
    input  wire bxc_pkg::bxc_word_t wide_bank_two_in,
    input  wire logic              wide_bank_two_ext_drive,
    output bxc_pkg::bxc_word_t     wide_bank_two_out,
    output logic                   wide_bank_two_oe
);

    // ============================================================
    // Bus-hold keepers
    // A keeper remembers the last level on each data pin. When nobody
    // drives the pin, the block sees that level instead of an unknown.
    logic               keep_en_r;
    bxc_pkg::bxc_word_t narrow_keep_r;
    bxc_pkg::bxc_word_t one_keep_r;
    bxc_pkg::bxc_word_t two_keep_r;
    bxc_pkg::bxc_word_t narrow_pin;
    bxc_pkg::bxc_word_t one_pin;
    bxc_pkg::bxc_word_t two_pin;

    always_comb begin
        if (narrow_ext_drive) begin
            narrow_pin = narrow_in;
        end else if (narrow_oe) begin
            narrow_pin = narrow_out;
        end else begin
            narrow_pin = keep_en_r ? narrow_keep_r : `BXC_WORD_RESET;
        end
    end

    always_comb begin
        if (wide_bank_one_ext_drive) begin
            one_pin = wide_bank_one_in;
        end else if (wide_bank_one_oe) begin
            one_pin = wide_bank_one_out;
        end else begin
            one_pin = keep_en_r ? one_keep_r : `BXC_WORD_RESET;
        end
    end

    always_comb begin
        if (wide_bank_two_ext_drive) begin
            two_pin = wide_bank_two_in;
        end else if (wide_bank_two_oe) begin
            two_pin = wide_bank_two_out;
        end else begin
            two_pin = keep_en_r ? two_keep_r : `BXC_WORD_RESET;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            narrow_keep_r <= `BXC_WORD_RESET;
            one_keep_r    <= `BXC_WORD_RESET;
            two_keep_r    <= `BXC_WORD_RESET;
        end else begin
            narrow_keep_r <= narrow_pin;
            one_keep_r    <= one_pin;
            two_keep_r    <= two_pin;
        end
    end

    // ============================================================
    // Narrow-to-wide capture registers
    bxc_pkg::bxc_word_t bank_one_r;
    bxc_pkg::bxc_word_t bank_two_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_one_r <= `BXC_WORD_RESET;
        end else if (!bank_one_capture_enable_n) begin
            bank_one_r <= narrow_pin;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_two_r <= `BXC_WORD_RESET;
        end else if (!bank_two_capture_enable_n) begin
            bank_two_r <= narrow_pin;
        end
    end

    // With both enables high neither register loads, so the wide
    // outputs keep showing the held words.
    assign wide_bank_one_out = bank_one_r;
    assign wide_bank_two_out = bank_two_r;

    // ============================================================
    // Wide-to-narrow transparent latches
    // Latches let read data reach the narrow port without a clock edge;
    // the price is that timing must close through the latch enables.
    bxc_pkg::bxc_word_t one_latch;
    bxc_pkg::bxc_word_t two_latch;

    always_latch begin
        if (!presetn) begin
            one_latch = `BXC_WORD_RESET;
        end else if (!bank_one_latch_open_n) begin
            one_latch = one_pin;
        end
    end

    always_latch begin
        if (!presetn) begin
            two_latch = `BXC_WORD_RESET;
        end else if (!bank_two_latch_open_n) begin
            two_latch = two_pin;
        end
    end

    assign narrow_out = bank_select ? one_latch : two_latch;

    // ============================================================
    // Output enables
    assign narrow_oe        = !narrow_drive_enable_n;
    assign wide_bank_one_oe = !wide_drive_enable_n;
    assign wide_bank_two_oe = !wide_drive_enable_n;

    // ============================================================
    // APB slave
    // Zero wait states; read data is registered in the setup cycle so it
    // is stable throughout the access phase.
    logic [`BXC_ADDR_W-1:0] addr;
    logic                   mapped;
    logic [31:0]            rdata_nxt;
    logic [31:0]            prdata_r;

    assign addr = paddr[`BXC_ADDR_W-1:0];

    always_comb begin
        mapped    = 1'b1;
        rdata_nxt = `BXC_RDATA_RESET;
        case (addr)
            `BXC_CTRL_OFF: begin
                rdata_nxt[`BXC_CTRL_KEEP_BIT] = keep_en_r;
            end
            `BXC_CAPTURE_OFF: begin
                rdata_nxt[2*`BXC_NARROW_W-1:0] = {bank_two_r, bank_one_r};
            end
            `BXC_LATCH_OFF: begin
                rdata_nxt[2*`BXC_NARROW_W-1:0] = {two_latch, one_latch};
            end
            `BXC_STATUS_OFF: begin
                rdata_nxt[`BXC_ST_SEL_BIT] = bank_select;
                rdata_nxt[`BXC_ST_NOE_BIT] = narrow_oe;
                rdata_nxt[`BXC_ST_WOE_BIT] = wide_bank_one_oe;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        if (paddr[31:`BXC_ADDR_W] != '0) begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= `BXC_RDATA_RESET;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keep_en_r <= `BXC_CTRL_RESET;
        end else if (psel && penable && pwrite && addr == `BXC_CTRL_OFF
                     && mapped) begin
            keep_en_r <= pwdata[`BXC_CTRL_KEEP_BIT];
        end
    end

    assign prdata  = prdata_r;
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !mapped;

endmodule

`default_nettype wire

// ==== rtl/bxc_pkg.sv ====
// Purpose: Types shared by the bus exchanger design.
// Assumes: Widths come from bxc_regs.svh.
// Notes:   Nothing here is imported; users write bxc_pkg::name.
`include "bxc_regs.svh"

package bxc_pkg;
    typedef logic [`BXC_NARROW_W-1:0]   bxc_word_t;
    typedef logic [2*`BXC_NARROW_W-1:0] bxc_wide_t;
endpackage

// ==== rtl/bxc_regs.svh ====
// Purpose: Constants for the 12-to-24 bit bus exchanger and its APB window.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Included by its bare name; definitions only.
`ifndef BXC_REGS_SVH
`define BXC_REGS_SVH

// ============================================================
// Widths
`define BXC_NARROW_W      12
`define BXC_ADDR_W        12

// ============================================================
// Register byte offsets
`define BXC_CTRL_OFF      12'h000
`define BXC_CAPTURE_OFF   12'h004
`define BXC_LATCH_OFF     12'h008
`define BXC_STATUS_OFF    12'h00C

// ============================================================
// Fields and reset values
`define BXC_CTRL_KEEP_BIT 0
`define BXC_CTRL_RESET    1'h1
`define BXC_WORD_RESET    12'h000
`define BXC_RDATA_RESET   32'h0000_0000
`define BXC_ST_SEL_BIT    0
`define BXC_ST_NOE_BIT    1
`define BXC_ST_WOE_BIT    2

`endif

// ==== test/bxc_exchanger_asserts.sv ====
// Purpose: Port checks. Assumes: inputs move after edges. Notes: bound.
`timescale 1ns/1ns
`default_nettype none
module bxc_exchanger_asserts (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               bank_one_capture_enable_n,
    input wire logic               bank_two_capture_enable_n,
    input wire logic               bank_one_latch_open_n,
    input wire logic               bank_two_latch_open_n,
    input wire logic               bank_select,
    input wire logic               narrow_ext_drive,
    input wire logic               wide_bank_one_ext_drive,
    input wire logic               wide_bank_two_ext_drive,
    input wire bxc_pkg::bxc_word_t narrow_in,
    input wire bxc_pkg::bxc_word_t narrow_out,
    input wire bxc_pkg::bxc_word_t wide_bank_one_in,
    input wire bxc_pkg::bxc_word_t wide_bank_two_in,
    input wire bxc_pkg::bxc_word_t wide_bank_one_out,
    input wire bxc_pkg::bxc_word_t wide_bank_two_out
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_shut;
        bank_one_latch_open_n && bank_two_latch_open_n;
    endsequence
    a_load_one: assert property (
        !bank_one_capture_enable_n && narrow_ext_drive |=>
        wide_bank_one_out == $past(narrow_in)) else $error("load one");
    a_load_two: assert property (
        !bank_two_capture_enable_n && narrow_ext_drive |=>
        wide_bank_two_out == $past(narrow_in)) else $error("load two");
    a_hold_one: assert property (bank_one_capture_enable_n |=>
        $stable(wide_bank_one_out)) else $error("hold one");
    a_hold_two: assert property (bank_two_capture_enable_n |=>
        $stable(wide_bank_two_out)) else $error("hold two");
    a_mux_one: assert property (
        !bank_one_latch_open_n && bank_select && wide_bank_one_ext_drive
        |-> narrow_out == wide_bank_one_in) else $error("mux one");
    a_mux_two: assert property (
        !bank_two_latch_open_n && !bank_select && wide_bank_two_ext_drive
        |-> narrow_out == wide_bank_two_in) else $error("mux two");
    a_latch_hold: assert property (
        s_shut ##1 s_shut ##0 $stable(bank_select) |-> $stable(narrow_out))
        else $error("latch hold");
    a_load_both: assert property (
        !bank_one_capture_enable_n && !bank_two_capture_enable_n |=>
        wide_bank_one_out == wide_bank_two_out) else $error("load both");
endmodule
`default_nettype wire

// ==== test/bxc_mem_model.sv ====
// Purpose: Wide-side memory. Assumes: one word a bank. Notes: none.
`timescale 1ns/1ns
`default_nettype none
module bxc_mem_model (
    input  wire logic        drive,
    input  wire logic [11:0] word_one,
    input  wire logic [11:0] word_two,
    output logic      [11:0] pin_one,
    output logic      [11:0] pin_two,
    output logic             ext
);
    // A released bus shows the inverse, so a stale value never matches.
    assign ext = drive;
    assign pin_one = drive ? word_one : ~word_one;
    assign pin_two = drive ? word_two : ~word_two;
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Exchanger bench. Assumes: bench is APB master. Notes: none.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic pclk = 1'h0;
    logic presetn, psel, penable, pwrite, pready, pslverr, e, mem_drv;
    logic [31:0] paddr, pwdata, prdata, r;
    logic bank_one_capture_enable_n, bank_two_capture_enable_n, bank_select;
    logic bank_one_latch_open_n, bank_two_latch_open_n, narrow_ext_drive;
    logic narrow_drive_enable_n, wide_drive_enable_n, narrow_oe;
    logic wide_bank_one_ext_drive, wide_bank_two_ext_drive;
    logic wide_bank_one_oe, wide_bank_two_oe;
    bxc_pkg::bxc_word_t narrow_in, narrow_out, w1, w2;
    bxc_pkg::bxc_word_t wide_bank_one_in, wide_bank_two_in;
    bxc_pkg::bxc_word_t wide_bank_one_out, wide_bank_two_out;
    int bad_count = 0;
    int tests_run = 0;
    bxc_exchanger bxc_exchanger_i (.*);
    bxc_mem_model bxc_mem_model_i (.drive(mem_drv), .word_one(w1),
        .word_two(w2), .pin_one(wide_bank_one_in),
        .pin_two(wide_bank_two_in), .ext(wide_bank_one_ext_drive));
    assign wide_bank_two_ext_drive = wide_bank_one_ext_drive;
    initial forever #25 pclk = ~pclk;
    task automatic stop_test(int hung);
        bad_count += hung;
        if (bad_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] x, g);
        tests_run++;
        if (x !== g) $display("FAIL %s expected %h seen %h", nm, x, g);
        bad_count += (x !== g);
    endtask
    task automatic apb(logic w, logic [31:0] a, d);
        int n = 0;
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge pclk) penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
        if (n == 20) stop_test(1);
        {r, e} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task automatic cap(logic [1:0] en_n, logic [11:0] v, logic x);
        @(posedge pclk);
        {bank_two_capture_enable_n, bank_one_capture_enable_n} <= en_n;
        {narrow_in, narrow_ext_drive} <= {v, x};
    endtask
    task automatic t_capture;
        apb(1'h0, 32'h0000_0000, 32'h0);
        chk("ctrl", 32'h1, r);
        cap(2'h2, 12'hA5C, 1'h1);
        cap(2'h1, 12'h3E1, 1'h1);
        cap(2'h3, 12'hFFF, 1'h1);
        cap(2'h3, 12'h6B2, 1'h1);
        #1;
        chk("one", 12'hA5C, wide_bank_one_out);
        chk("two", 12'h3E1, wide_bank_two_out);
        apb(1'h0, 32'h0000_0004, 32'h0);
        chk("capture", 32'h003E_1A5C, r);
        cap(2'h2, 12'h94D, 1'h0);
        cap(2'h3, 12'h94D, 1'h0);
        #1;
        chk("keeper", 12'h6B2, wide_bank_one_out);
        apb(1'h1, 32'h0000_0000, 32'h0);
        cap(2'h2, 12'h94D, 1'h0);
        cap(2'h3, 12'h94D, 1'h0);
        #1;
        chk("no_keeper", 12'h0, wide_bank_one_out);
        apb(1'h0, 32'h0000_0010, 32'h0);
        chk("unmapped", 32'h1, e);
    endtask
    task automatic t_latch;
        @(posedge pclk) {mem_drv, w1, w2} <= {1'h1, 12'h1C7, 12'hE38};
        {bank_one_latch_open_n, bank_two_latch_open_n, bank_select} <= 3'h1;
        #1;
        chk("sel_one", 12'h1C7, narrow_out);
        @(posedge pclk) bank_select <= 1'h0;
        #1;
        chk("sel_two", 12'hE38, narrow_out);
        @(posedge pclk) {bank_one_latch_open_n, bank_two_latch_open_n} <= 2'h3;
        @(posedge pclk) {mem_drv, w2} <= {1'h0, 12'h555};
        #1;
        chk("held", 12'hE38, narrow_out);
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            {wide_drive_enable_n, narrow_drive_enable_n} <= k[1:0];
            #1;
            chk("oe", {~k[1], ~k[1], ~k[0]},
                {wide_bank_one_oe, wide_bank_two_oe, narrow_oe});
        end
    endtask
    task automatic t_reset;
        cap(2'h0, 12'h2D4, 1'h1);
        cap(2'h3, 12'h2D4, 1'h1);
        #1;
        chk("both_one", 12'h2D4, wide_bank_one_out);
        chk("both_two", 12'h2D4, wide_bank_two_out);
        @(posedge pclk) presetn <= 1'h0;
        @(posedge pclk);
        #1;
        chk("rst_one", 12'h0, wide_bank_one_out);
        chk("rst_two", 12'h0, wide_bank_two_out);
        chk("rst_out", 12'h0, narrow_out);
        @(posedge pclk) presetn <= 1'h1;
        apb(1'h0, 32'h0000_0000, 32'h0);
        chk("rst_ctrl", 32'h1, r);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, mem_drv} = '0;
        {narrow_in, narrow_ext_drive, w1, w2, wide_drive_enable_n} = '0;
        {bank_one_capture_enable_n, bank_two_capture_enable_n} = 2'h3;
        {bank_one_latch_open_n, bank_two_latch_open_n} = 2'h3;
        {bank_select, narrow_drive_enable_n} = 2'h1;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        t_capture;
        t_latch;
        t_reset;
        stop_test(0);
    end
endmodule
bind bxc_exchanger bxc_exchanger_asserts bxc_exchanger_asserts_i (.*);
`default_nettype wire
